// ---- inc/rqd_map.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  receive-queue delivery block.
  Assumes byte addresses on an 8-bit register address and 16-bit data.
*/
`ifndef RQD_MAP_SVH
`define RQD_MAP_SVH

// Register byte offsets.
`define RQD_RC1_OFF          8'h74
`define RQD_RC2_OFF          8'h76
`define RQD_HSTS_OFF         8'h7c
`define RQD_HLEN_OFF         8'h7e
`define RQD_QCTL_OFF         8'h82
`define RQD_DPTR_OFF         8'h86
`define RQD_DTT_OFF          8'h8c
`define RQD_DBT_OFF          8'h8e
`define RQD_IE_OFF           8'h90
`define RQD_IS_OFF           8'h92
`define RQD_FCTR_OFF         8'h9c
`define RQD_QDATA_OFF        8'hd0

// Field positions.
`define RQD_RC1_BLOCK_BIT    0
`define RQD_RC1_FLOW_BIT     10
`define RQD_RC2_CSUM_LSB     1
`define RQD_QC_RELEASE_BIT   0
`define RQD_QC_DMA_BIT       3
`define RQD_QC_AUTODQ_BIT    4
`define RQD_QC_FCNT_EN_BIT   5
`define RQD_QC_BCNT_EN_BIT   6
`define RQD_QC_TIME_EN_BIT   7
`define RQD_QC_IPOFF_BIT     9
`define RQD_QC_STAT_LSB      10
`define RQD_QC_WR_MASK       16'h02f8
`define RQD_DPTR_AUTO_BIT    14
`define RQD_DPTR_WR_MASK     16'h47ff
`define RQD_RX_INT_BIT       13

// Reset values.
`define RQD_RC1_RST          16'h0000
`define RQD_RC2_RST          16'h0000
`define RQD_QC_RST           16'h0000
`define RQD_DPTR_RST         16'h0000
`define RQD_THR_RST          16'h0000

// Frame layout and limits.
`define RQD_HDR_WORDS        2
`define RQD_HDR_BYTES        4
`define RQD_MAX_DATA_BYTES   2000
`define RQD_OFFSET_BYTES     2

// Timing: the duration threshold counts microseconds.
`define RQD_US_NS            1000
`define RQD_CLK_NS           8
`define RQD_US_CYCLES        (`RQD_US_NS / `RQD_CLK_NS)

`endif

// ---- inc/rqd_pkg.sv ----
/*
  Types of the receive-queue delivery block.
  Assumes the queue address fits RQD_AW bits.
*/
package rqd_pkg;

  localparam int RQD_AW = 13;

  typedef enum logic [1:0] {
    ING_IDLE,
    ING_DATA,
    ING_STAT,
    ING_LEN
  } rqd_ing_t;

  // One beat of a received frame from the MAC.
  typedef struct packed {
    logic        valid;
    logic        sof;
    logic        eof;
    logic        odd;
    logic [15:0] data;
    logic [15:0] status;
  } rqd_rx_t;

  typedef struct packed {
    rqd_ing_t            ist;
    logic [15:0]         rc1;
    logic [15:0]         rc2;
    logic [15:0]         qc;
    logic [15:0]         dptr;
    logic [15:0]         dtt;
    logic [15:0]         dbt;
    logic [15:0]         ie;
    logic                interrupt_status;
    logic [7:0]          fthr;
    logic [7:0]          fsnap;
    logic [15:0]         hsts;
    logic [15:0]         hlen;
    logic [1:0]          hseen;
    logic [RQD_AW-1:0]   pk;
    logic [RQD_AW-1:0]   hp;
    logic [RQD_AW-1:0]   fb;
    logic [RQD_AW-1:0]   iw;
    logic [RQD_AW-1:0]   wp;
    logic [RQD_AW:0]     used;
    logic [15:0]         fcnt;
    logic [15:0]         bytes;
    logic [11:0]         cnt;
    logic                drop;
    logic [15:0]         fstat;
    logic                dummy;
    logic [6:0]          pre;
    logic [15:0]         age;
    logic [2:0]          cprev;
    logic [15:0]         rdata;
    logic                irq;
  } rqd_state_t;

endpackage

// ---- rtl/rqd_rx_queue.sv ----
/*
  Receive queue with host delivery: stores MAC frames behind a status and
  length header, serves header, control and data registers to the host.
  Assumes a synchronous register port with one-cycle read latency and a MAC
  that leaves at least two idle cycles after each end of frame.
*/
`timescale 1ns/1ps
`include "rqd_map.svh"

module rqd_rx_queue
  import rqd_pkg::*;
#(
  parameter int DEPTH = 6144
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Register port.
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [1:0]  i_reg_be,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  input  wire logic        i_big_endian,
  // Frames from the MAC.
  input  wire rqd_rx_t     i_rx,
  // Controls and interrupt.
  output logic             o_rx_flow_en,
  output logic             o_rx_block_en,
  output logic      [3:0]  o_rx_csum_en,
  output logic             o_rx_int
);

  localparam logic [RQD_AW:0] DEPTH_L = (RQD_AW + 1)'(DEPTH);

  if (DEPTH < 2048 || DEPTH > (1 << RQD_AW)) begin : g_chk
    $error("DEPTH must lie between 2048 and 2**RQD_AW words");
  end

  rqd_state_t        q;
  rqd_state_t        d;
  // The frame store has no reset: a frame is counted only after its status
  // and length words are written, so a frame counter read with a frame queued never loads stale status or length words.
  logic [15:0]       mem [DEPTH];
  logic              mwe;
  logic [RQD_AW-1:0] mwa;
  logic [15:0]       mwd;

  function automatic logic [RQD_AW-1:0] wadd(
      input logic [RQD_AW-1:0] a,
      input logic [RQD_AW-1:0] b);
    logic [RQD_AW:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= DEPTH_L) begin
      s = s - DEPTH_L;
    end
    return s[RQD_AW-1:0];
  endfunction

  // Words a frame takes: header plus data rounded to a double word.
  function automatic logic [RQD_AW-1:0] fwords(input logic [11:0] c);
    logic [12:0] t;
    logic [11:0] w;
    t = {1'b0, c} + 13'h003;
    w = {t[12:2], 1'b0} + 12'h002;
    return RQD_AW'(w);
  endfunction

  function automatic logic [15:0] wmerge(
      input logic [15:0] old,
      input logic [15:0] wd,
      input logic [1:0]  be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Admission needs room for a longest frame or skips the frame: some space is traded for
  // an ingest path that never has to undo a half-written frame.
  logic [RQD_AW-1:0] max_words;
  assign max_words = fwords(12'(`RQD_MAX_DATA_BYTES + `RQD_OFFSET_BYTES));

  always_comb begin
    logic [RQD_AW:0]   add_w;
    logic [RQD_AW:0]   sub_w;
    logic [15:0]       add_b;
    logic [15:0]       sub_b;
    logic              inc;
    logic              deq;
    logic [11:0]       hcnt;
    logic [RQD_AW-1:0] hw;
    logic [11:0]       ncnt;
    logic [11:0]       off;
    logic [15:0]       word;
    logic [RQD_AW-1:0] a;
    logic [2:0]        cond;
    logic              set;
    logic              clr;
    logic              wr;
    logic              rd;
    d     = q;
    mwe   = 1'b0;
    mwa   = '0;
    mwd   = 16'h0000;
    add_w = '0;
    sub_w = '0;
    add_b = 16'h0000;
    sub_b = 16'h0000;
    inc   = 1'b0;
    deq   = 1'b0;
    hcnt  = mem[wadd(q.hp, RQD_AW'(1))][11:0];
    hw    = fwords(hcnt);
    ncnt  = q.cnt + ((i_rx.eof && i_rx.odd) ? 12'h001 : 12'h002);
    off   = q.qc[`RQD_QC_IPOFF_BIT] ? 12'(`RQD_OFFSET_BYTES) : 12'h000;
    word  = 16'h0000;
    a     = '0;
    wr    = i_reg_wr;
    rd    = i_reg_rd;
    cond  = 3'b000;
    set   = 1'b0;
    clr   = 1'b0;

    // Frame ingest from the MAC.
    case (q.ist)
      ING_IDLE: begin
        if (i_rx.valid && i_rx.sof &&
            (DEPTH_L - q.used) >= {1'b0, max_words}) begin
          d.fb  = q.wp;
          d.ist = ING_DATA;
          d.drop = 1'b0;
          // Offset bytes keep stale memory; the host skips them anyway.
          a     = wadd(q.wp,
                       RQD_AW'(`RQD_HDR_WORDS + (off >> 1)));
          ncnt  = off + ((i_rx.eof && i_rx.odd) ? 12'h001 : 12'h002);
          mwe   = 1'b1;
          mwa   = a;
          mwd   = i_rx.data;
          d.iw  = wadd(a, RQD_AW'(1));
          d.cnt = ncnt;
          if (i_rx.eof) begin
            d.fstat = i_rx.status;
            d.ist   = ING_STAT;
          end
        end
      end
      ING_DATA: begin
        if (i_rx.valid) begin
          // Once a frame runs long, its remaining beats are swallowed.
          if ((ncnt - off) > 12'(`RQD_MAX_DATA_BYTES) || q.drop) begin
            d.drop = 1'b1;
          end else begin
            mwe   = 1'b1;
            mwa   = q.iw;
            mwd   = i_rx.data;
            d.iw  = wadd(q.iw, RQD_AW'(1));
            d.cnt = ncnt;
          end
          if (i_rx.eof) begin
            d.fstat = i_rx.status;
            d.ist   = (d.drop) ? ING_IDLE : ING_STAT;
          end
        end
      end
      ING_STAT: begin
        mwe   = 1'b1;
        mwa   = q.fb;
        mwd   = q.fstat;
        d.ist = ING_LEN;
      end
      ING_LEN: begin
        mwe   = 1'b1;
        mwa   = wadd(q.fb, RQD_AW'(1));
        mwd   = {4'h0, q.cnt};
        d.wp  = wadd(q.fb, fwords(q.cnt));
        add_w = {1'b0, fwords(q.cnt)};
        add_b = {4'h0, q.cnt};
        inc   = 1'b1;
        d.ist = ING_IDLE;
      end
      default: begin
        d.ist = ING_IDLE;
      end
    endcase

    // Register writes.
    if (wr) begin
      if (i_reg_addr == `RQD_RC1_OFF) begin
        d.rc1 = wmerge(q.rc1, i_reg_wdata, i_reg_be);
      end else if (i_reg_addr == `RQD_RC2_OFF) begin
        d.rc2 = wmerge(q.rc2, i_reg_wdata, i_reg_be);
      end else if (i_reg_addr == `RQD_QCTL_OFF) begin
        d.qc = wmerge(q.qc, i_reg_wdata, i_reg_be) & `RQD_QC_WR_MASK;
        if (d.qc[`RQD_QC_DMA_BIT] && !q.qc[`RQD_QC_DMA_BIT]) begin
          d.dummy = 1'b1;
        end
        if (i_reg_be[0] && i_reg_wdata[`RQD_QC_RELEASE_BIT]) begin
          deq = 1'b1;
        end
      end else if (i_reg_addr == `RQD_DPTR_OFF) begin
        d.dptr = wmerge(q.dptr, i_reg_wdata, i_reg_be) & `RQD_DPTR_WR_MASK;
      end else if (i_reg_addr == `RQD_DTT_OFF) begin
        d.dtt = wmerge(q.dtt, i_reg_wdata, i_reg_be);
      end else if (i_reg_addr == `RQD_DBT_OFF) begin
        d.dbt = wmerge(q.dbt, i_reg_wdata, i_reg_be);
      end else if (i_reg_addr == `RQD_IE_OFF) begin
        d.ie = wmerge(q.ie, i_reg_wdata, i_reg_be);
      end else if (i_reg_addr == `RQD_FCTR_OFF && i_reg_be[0]) begin
        d.fthr = i_reg_wdata[7:0];
      end
    end
    // Only bit 13 exists, so a clear needs just the high byte enable.
    clr = wr && i_reg_addr == `RQD_IS_OFF && i_reg_be[1] &&
          i_reg_wdata[`RQD_RX_INT_BIT];
    if (clr) begin
      d.fsnap = q.fcnt[7:0];
    end

    // Register reads and their side effects.
    if (rd) begin
      d.rdata = 16'h0000;
      if (i_reg_addr == `RQD_RC1_OFF) begin
        d.rdata = q.rc1;
      end else if (i_reg_addr == `RQD_RC2_OFF) begin
        d.rdata = q.rc2;
      end else if (i_reg_addr == `RQD_HSTS_OFF) begin
        d.rdata    = q.hsts;
        d.hseen[0] = 1'b1;
      end else if (i_reg_addr == `RQD_HLEN_OFF) begin
        d.rdata    = {4'h0, q.hlen[11:0]};
        d.hseen[1] = 1'b1;
      end else if (i_reg_addr == `RQD_QCTL_OFF) begin
        d.rdata = q.qc |
                  {3'b000, q.cprev, 10'h000};
      end else if (i_reg_addr == `RQD_DPTR_OFF) begin
        d.rdata = q.dptr;
      end else if (i_reg_addr == `RQD_DTT_OFF) begin
        d.rdata = q.dtt;
      end else if (i_reg_addr == `RQD_DBT_OFF) begin
        d.rdata = q.dbt;
      end else if (i_reg_addr == `RQD_IE_OFF) begin
        d.rdata = q.ie;
      end else if (i_reg_addr == `RQD_IS_OFF) begin
        d.rdata = 16'(q.interrupt_status) << `RQD_RX_INT_BIT;
      end else if (i_reg_addr == `RQD_FCTR_OFF) begin
        d.rdata = {q.fsnap, q.fthr};
        d.pk    = q.hp;
        d.hsts  = mem[q.hp];
        d.hlen  = mem[wadd(q.hp, RQD_AW'(1))];
        d.hseen = 2'b00;
      end else if (i_reg_addr == `RQD_QDATA_OFF && q.fcnt != 16'h0000) begin
        if (q.dummy) begin
          d.dummy = 1'b0;
        end else begin
          word = mem[wadd(q.hp, RQD_AW'(q.dptr[10:1]))];
          if (i_big_endian && q.dptr[10:0] < 11'(`RQD_HDR_BYTES)) begin
            word = {word[7:0], word[15:8]};
          end
          d.rdata = word;
          if (q.dptr[`RQD_DPTR_AUTO_BIT]) begin
            d.dptr[10:0] = q.dptr[10:0] + 11'h002;
            // End of a padded frame: the host has read to the boundary.
            if (q.qc[`RQD_QC_AUTODQ_BIT] && q.qc[`RQD_QC_DMA_BIT] &&
                {1'b0, d.dptr[10:1]} >= 11'(hw)) begin
              deq = 1'b1;
            end
          end
        end
      end
    end
    // With no later frame queued the registers show stale words until the
    // host reads the frame counter again.
    if (d.hseen == 2'b11) begin
      a       = wadd(q.pk, fwords(q.hlen[11:0]));
      d.pk    = a;
      d.hsts  = mem[a];
      d.hlen  = mem[wadd(a, RQD_AW'(1))];
      d.hseen = 2'b00;
    end

    // Dequeue of the head frame.
    // A release on an empty queue is ignored so the counters cannot wrap.
    if (deq && q.fcnt != 16'h0000) begin
      d.hp         = wadd(q.hp, hw);
      sub_w        = {1'b0, hw};
      sub_b        = {4'h0, hcnt};
      d.dptr[10:0] = 11'h000;
      d.age        = 16'h0000;
      d.pre        = 7'h00;
    end
    d.used = q.used + add_w - sub_w;
    d.bytes = q.bytes + add_b - sub_b;
    d.fcnt = q.fcnt + (inc ? 16'h0001 : 16'h0000) -
             ((deq && q.fcnt != 16'h0000) ? 16'h0001 : 16'h0000);

    // Residence time of the oldest frame in microseconds.
    if (q.fcnt == 16'h0000) begin
      d.age = 16'h0000;
      d.pre = 7'h00;
    end else if (!(deq && q.fcnt != 16'h0000)) begin
      if (q.pre == 7'(`RQD_US_CYCLES - 1)) begin
        d.pre = 7'h00;
        if (q.age != 16'hffff) begin
          d.age = q.age + 16'h0001;
        end
      end else begin
        d.pre = q.pre + 7'h01;
      end
    end

    // Thresholds; only a new crossing sets the sticky status.
    cond[0] = q.qc[`RQD_QC_FCNT_EN_BIT] &&
              q.fcnt > {8'h00, q.fthr};
    cond[1] = q.qc[`RQD_QC_BCNT_EN_BIT] && q.bytes > q.dbt;
    cond[2] = q.qc[`RQD_QC_TIME_EN_BIT] && q.age > q.dtt;
    d.cprev = cond;
    set     = |(cond & ~q.cprev);
    d.interrupt_status   = set | (q.interrupt_status & ~clr);
    d.irq   = d.interrupt_status & q.ie[`RQD_RX_INT_BIT];
  end

  // Single write port; the ingest path is the only writer of the store.
  always_ff @(posedge i_clk) begin
    if (mwe) begin
      mem[mwa] <= mwd;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q       <= '0;
      q.ist   <= ING_IDLE;
      q.rc1   <= `RQD_RC1_RST;
      q.rc2   <= `RQD_RC2_RST;
      q.qc    <= `RQD_QC_RST;
      q.dptr  <= `RQD_DPTR_RST;
      q.dtt   <= `RQD_THR_RST;
      q.dbt   <= `RQD_THR_RST;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata   = q.rdata;
  assign o_rx_flow_en  = q.rc1[`RQD_RC1_FLOW_BIT];
  assign o_rx_block_en = q.rc1[`RQD_RC1_BLOCK_BIT];
  assign o_rx_csum_en  = q.rc2[`RQD_RC2_CSUM_LSB +: 4];
  assign o_rx_int      = q.irq;

endmodule

// ---- verification/rqd_host_model.sv ----
/*
  Host processor model driving the register port of the receive queue.
  Assumes the bench pops exp_q once for every read that this model makes.
*/
`timescale 1ns/1ps
module rqd_host (
  // Clock.
  input  wire logic        i_clk,
  // Register port towards the queue.
  output logic      [7:0]  o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [1:0]  o_be,
  output logic      [15:0] o_wdata
);
  // Each entry is {mask, expected}; a zero mask marks a discarded read.
  logic [31:0] exp_q[$];

  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_be = 2'h3;
    o_wdata = 16'h0000;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    exp_q.push_back({m, e});
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
  endtask

  // Reading on to the padded end is what lets auto-dequeue retire a frame.
  task automatic rd_frame(input logic [15:0] e[36],
                          input logic [15:0] m[36]);
    rd(8'hd0, 16'h0000, 16'h0000);
    for (int w = 0; w < 36; w++) begin
      rd(8'hd0, e[w], m[w]);
    end
  endtask
endmodule

// ---- verification/rqd_rx_queue_sva.sv ----
/*
  Checker of the register port and control outputs of the receive queue.
  Assumes it is bound to rqd_rx_queue and sees only its ports.
*/
`timescale 1ns/1ps
module rqd_chk (
  // Clock and reset.
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  // Register port and outputs of the queue.
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [1:0]  i_reg_be,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        o_rx_flow_en,
  input wire logic        o_rx_block_en,
  input wire logic [3:0]  o_rx_csum_en,
  input wire logic        o_rx_int
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_flow_follows: assert property (
    i_reg_wr && i_reg_addr == 8'h74 && i_reg_be[1]
    |=> o_rx_flow_en == $past(i_reg_wdata[10])) else $error("flow en");
  a_block_follows: assert property (
    i_reg_wr && i_reg_addr == 8'h74 && i_reg_be[0]
    |=> o_rx_block_en == $past(i_reg_wdata[0])) else $error("block en");
  a_csum_follows: assert property (
    i_reg_wr && i_reg_addr == 8'h76 && i_reg_be[0]
    |=> o_rx_csum_en == $past(i_reg_wdata[4:1])) else $error("csum en");
  a_unmapped_zero: assert property (
    i_reg_rd && i_reg_addr < 8'h70
    |=> o_reg_rdata == 16'h0000) else $error("unmapped read");
  a_status_only13: assert property (
    i_reg_rd && i_reg_addr == 8'h92
    |=> (o_reg_rdata & 16'hdfff) == 16'h0000) else $error("status bits");
  a_rdata_holds: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
  a_int_gated: assert property (
    i_reg_wr && i_reg_addr == 8'h90 && i_reg_be[1] && !i_reg_wdata[13]
    |-> ##2 !o_rx_int) else $error("int not gated");
  a_fthr_readback: assert property (
    i_reg_wr && i_reg_addr == 8'h9c && i_reg_be[0]
    ##2 i_reg_rd && i_reg_addr == 8'h9c
    |=> o_reg_rdata[7:0] == $past(i_reg_wdata[7:0], 3))
    else $error("frame threshold");
  a_qctl_readback: assert property (
    i_reg_wr && i_reg_addr == 8'h82 && i_reg_be == 2'h3
    ##2 i_reg_rd && i_reg_addr == 8'h82
    |=> (o_reg_rdata & 16'h02f9) == ($past(i_reg_wdata, 3) & 16'h02f8))
    else $error("queue control");
endmodule

bind rqd_rx_queue rqd_chk chk_i (
  .i_clk         (i_clk),
  .i_reset_n     (i_reset_n),
  .i_reg_addr    (i_reg_addr),
  .i_reg_wr      (i_reg_wr),
  .i_reg_rd      (i_reg_rd),
  .i_reg_be      (i_reg_be),
  .i_reg_wdata   (i_reg_wdata),
  .o_reg_rdata   (o_reg_rdata),
  .o_rx_flow_en  (o_rx_flow_en),
  .o_rx_block_en (o_rx_block_en),
  .o_rx_csum_en  (o_rx_csum_en),
  .o_rx_int      (o_rx_int)
);

// ---- verification/tb.sv ----
/*
  Self-checking bench: a MAC driver feeds frames, the host model reads
  thresholds, headers and frame data back.
  Assumes rqd_pkg is compiled first.
*/
`timescale 1ns/1ps
module tb;
  import rqd_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_big_endian = 1'b0;
  rqd_rx_t     i_rx = '0;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [1:0]  reg_be;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        rx_int;
  logic        rd_d;
  int          n_mismatch = 0;
  int          compares = 0;
  int          seed = 33;
  int          d;
  logic [15:0] dat[33];
  logic [15:0] ew[36];
  logic [15:0] mw[36];
  logic [15:0] r;
  logic [15:0] st;
  logic [15:0] en;
  logic [15:0] cnt;
  logic [31:0] ent;

  always #4 i_clk = ~i_clk;

  rqd_rx_queue dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_be(reg_be), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_big_endian(i_big_endian), .i_rx(i_rx), .o_rx_flow_en(),
    .o_rx_block_en(), .o_rx_csum_en(), .o_rx_int(rx_int));
  rqd_host hst (.i_clk(i_clk), .o_addr(reg_addr), .o_wr(reg_wr),
    .o_rd(reg_rd), .o_be(reg_be), .o_wdata(reg_wdata));

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Read data shows up one cycle after the strobe edge.
  always @(posedge i_clk) begin
    if (rd_d === 1'b1 && hst.exp_q.size() > 0) begin
      ent = hst.exp_q.pop_front();
      if (ent[31:16] != 16'h0000) begin
        chk("reg_rdata", reg_rdata & ent[31:16], ent[15:0] & ent[31:16]);
      end
    end
    rd_d <= reg_rd;
  end

  task automatic wait_int(input logic lvl);
    int i;
    for (i = 0; i < 2000 && rx_int !== lvl; i++) begin
      @(posedge i_clk);
    end
    chk("rx_int", {15'h0, rx_int}, {15'h0, lvl});
    if (i == 2000) begin
      complete_run();
    end
  endtask

  task automatic send(input int len, input logic [15:0] s);
    int nw;
    nw = (len + 1) / 2;
    for (int i = 0; i < nw; i++) begin
      @(posedge i_clk);
      i_rx <= '{valid: 1'b1, sof: i == 0, eof: i == nw - 1, odd: len[0],
                data: dat[i], status: s};
    end
    @(posedge i_clk);
    i_rx <= '0;
    repeat (4) @(posedge i_clk);
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = 16'($random(seed));
      hst.wr(8'h74, r);
      hst.rd(8'h74, r, 16'h0401);
      hst.wr(8'h76, r);
      hst.rd(8'h76, r, 16'h001e);
    end
    hst.rd(8'h00, 16'h0000, 16'hffff);
    hst.wr(8'h90, 16'h0000);
    hst.wr(8'h9c, 16'hff00);
    hst.rd(8'h9c, 16'h0000, 16'h00ff);
    hst.wr(8'h90, 16'h2000);
    hst.wr(8'h8e, 16'd60);
    hst.wr(8'h8c, 16'h0001);
    // Pass k uses frame, byte and duration thresholds in turn.
    for (int k = 0; k < 3; k++) begin
      en = (16'h0020 << k) | (k == 2 ? 16'h0200 : 16'h0000);
      cnt = (k == 2) ? 16'd67 : 16'd65;
      i_big_endian <= k[0];
      hst.wr(8'h82, en);
      hst.rd(8'h82, en, 16'h02f8);
      for (int i = 0; i < 33; i++) begin
        dat[i] = 16'($random(seed));
      end
      st = 16'($random(seed));
      send(65, st);
      wait_int(1'b1);
      hst.rd(8'h92, 16'h2000, 16'hffff);
      hst.rd(8'h82, 16'h0400 << k, 16'h0400 << k);
      hst.wr(8'h92, 16'hffff);
      wait_int(1'b0);
      hst.rd(8'h9c, 16'h0100, 16'hff00);
      hst.rd(8'h7c, st, 16'hffff);
      hst.rd(8'h7e, cnt, 16'h0fff);
      for (int w = 0; w < 36; w++) begin
        d = w - 2 - (k == 2 ? 1 : 0);
        ew[w] = (d >= 0 && d < 33) ? dat[d] : 16'h0000;
        mw[w] = (d >= 0 && d < 32) ? 16'hffff
              : (d == 32 ? 16'h00ff : 16'h0000);
      end
      ew[0] = k[0] ? {st[7:0], st[15:8]} : st;
      ew[1] = k[0] ? {cnt[7:0], cnt[15:8]} : cnt;
      mw[0] = 16'hffff;
      mw[1] = 16'hffff;
      hst.wr(8'h86, 16'h4000);
      hst.wr(8'h82, en | 16'h0018);
      hst.rd_frame(ew, mw);
      hst.rd(8'h82, 16'h0000, 16'h0400 << k);
      hst.wr(8'h82, 16'h0000);
    end
    // Two frames queued: reading both headers moves on to the second one.
    send(65, st);
    send(40, ~st);
    hst.rd(8'h9c, 16'h0000, 16'h00ff);
    hst.rd(8'h7c, st, 16'hffff);
    hst.rd(8'h7e, 16'd65, 16'h0fff);
    hst.rd(8'h7c, ~st, 16'hffff);
    hst.rd(8'h7e, 16'd40, 16'h0fff);
    repeat (5) @(posedge i_clk);
    complete_run();
  end
endmodule
